// ---- hdl/pcrs_top.sv ----
// The placing of the registers and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/100ps

module pcrs_top
    import pcrs_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic step_req,
    input wire logic call_req,
    input wire logic [PC_W-1:0] call_target,
    input wire logic jump_req,
    input wire logic [PC_W-1:0] jump_target,
    input wire logic ret_req,
    input wire logic irq_ack,
    input wire logic irq_high,
    input wire logic wake_irq,
    input wire logic global_irq_enable_high,
    input wire logic global_irq_enable_low,
    output logic [PC_W-1:0] pc,
    output logic device_reset,
    output logic irq
);

    pcrs_state_t s_q;
    pcrs_state_t s_d;

    ////////////////////////////////////////////////////////////////////////
    // register read mux and stack byte-write helper

    // stack top value; pointer zero has no storage behind it
    function automatic logic [PC_W-1:0] top_of(input pcrs_state_t st);
        logic [PC_W-1:0] v;
        v = '0;
        if (st.sp != SP_ZERO) begin
            v = st.stk[st.sp - SP_ONE];
        end
        return v;
    endfunction : top_of

    // replace one byte lane of a stack word; the upper lane is only five
    // bits wide, so the spare bits of its write byte are dropped
    function automatic logic [PC_W-1:0] with_byte(
        input logic [PC_W-1:0] w,
        input logic [ADDR_W-1:0] a,
        input logic [7:0] b
    );
        logic [PC_W-1:0] v;
        v = w;
        if (a == OFS_TOP_LOW) begin
            v[7:0] = b;
        end else if (a == OFS_TOP_HIGH) begin
            v[15:8] = b;
        end else begin
            v[20:16] = b[4:0];
        end
        return v;
    endfunction : with_byte

    // one word per register; the response code rides above the data
    // so that a single return value carries both
    function automatic logic [DATA_W+1:0] read_word(
        input pcrs_state_t st,
        input logic [ADDR_W-1:0] a
    );
        logic [DATA_W-1:0] d;
        logic [PC_W-1:0] t;
        logic [1:0] r;
        d = '0;
        r = RESP_OKAY;
        t = top_of(st);
        unique case (a)
            OFS_PC_LOW: d[7:0] = st.pc[7:0];
            OFS_HIGH_LATCH: d[LATH_W-1:0] = st.lath;
            OFS_UPPER_LATCH: d[LATU_W-1:0] = st.latu;
            OFS_TOP_LOW: d[7:0] = t[7:0];
            OFS_TOP_HIGH: d[7:0] = t[15:8];
            OFS_TOP_UPPER: d[4:0] = t[20:16];
            // flags ride above the pointer so one read shows all of it
            OFS_STACK_PTR: begin
                d[SP_W-1:0] = st.sp;
                d[SPR_UNF_BIT] = st.unf;
                d[SPR_FULL_BIT] = st.full;
            end
            OFS_CTRL: d[CTRL_OVR_BIT] = st.ovr_en;
            OFS_IRQ_STATUS: d[EV_W-1:0] = st.sts;
            OFS_IRQ_CLEAR: d = '0; // write-only, reads zero
            OFS_IRQ_ENABLE: d[EV_W-1:0] = st.ena;
            default: r = RESP_SLVERR;
        endcase
        return {r, d};
    endfunction : read_word

    ////////////////////////////////////////////////////////////////////////
    // next-state logic: bus side first, core operations last so they win

    always_comb begin
        logic [EV_W-1:0] ev;
        logic [EV_W-1:0] clr;
        logic [DATA_W+1:0] rw;
        logic [7:0] wb;
        logic [PC_W-1:0] t;
        logic wake_go;
        logic push;
        logic [PC_W-1:0] push_to;
        logic [PC_W-1:0] ret_addr;
        logic [SP_W-1:0] sp_up;
        logic at_top;
        logic ovr_hit;
        ev = '0;
        clr = '0;
        rw = '0;
        wb = '0;
        t = '0;
        wake_go = 1'b0;
        push = 1'b0;
        push_to = '0;
        ret_addr = '0;
        sp_up = '0;
        at_top = 1'b0;
        ovr_hit = 1'b0;
        s_d = s_q;
        s_d.rst_pulse = 1'b0;

        // write address and data are taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            s_d.aw_got = 1'b1;
            s_d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_d.w_got = 1'b1;
            s_d.wdata = s_axi_wdata;
            s_d.wlane0 = s_axi_wstrb[0];
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end

        // read: answer one cycle after the address is taken
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rw = read_word(s_q, s_axi_araddr);
            s_d.rdata = rw[DATA_W-1:0];
            s_d.rresp = rw[DATA_W+1:DATA_W];
            s_d.rvalid = 1'b1;
            // snapshot the upper counter bytes so software can rebuild the
            // full address from the latches after this low-byte read
            if (s_axi_araddr == OFS_PC_LOW) begin
                s_d.lath = s_q.pc[15:8];
                s_d.latu = s_q.pc[20:16];
            end
        end

        // registered write once both halves are held; only lane 0 matters
        // since every register is at most one byte wide; the other lanes
        // are accepted and dropped without an error
        if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
            s_d.aw_got = 1'b0;
            s_d.w_got = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = RESP_OKAY;
            wb = s_q.wdata[7:0];
            t = top_of(s_q);
            unique case (s_q.awaddr)
                OFS_PC_LOW: if (s_q.wlane0) begin
                    // latches move into the counter; bit 0 forced clear
                    s_d.pc = {s_q.latu, s_q.lath, wb[7:1], 1'b0};
                end
                OFS_HIGH_LATCH: if (s_q.wlane0) begin
                    s_d.lath = wb;
                end
                OFS_UPPER_LATCH: if (s_q.wlane0) begin
                    s_d.latu = wb[LATU_W-1:0];
                end
                OFS_TOP_LOW, OFS_TOP_HIGH, OFS_TOP_UPPER: begin
                    // pointer zero has nothing to replace: write dropped
                    if (s_q.wlane0 && s_q.sp != SP_ZERO) begin
                        t = with_byte(t, s_q.awaddr, wb);
                        s_d.stk[s_q.sp - SP_ONE] = t;
                    end
                end
                OFS_STACK_PTR: if (s_q.wlane0) begin
                    s_d.sp = wb[SP_W-1:0];
                    s_d.unf = wb[SPR_UNF_BIT];
                    s_d.full = wb[SPR_FULL_BIT];
                end
                OFS_CTRL: if (s_q.wlane0) begin
                    s_d.ovr_en = wb[CTRL_OVR_BIT];
                end
                OFS_IRQ_STATUS: s_d.bresp = RESP_OKAY; // read-only
                OFS_IRQ_CLEAR: if (s_q.wlane0) begin
                    clr = wb[EV_W-1:0];
                end
                OFS_IRQ_ENABLE: if (s_q.wlane0) begin
                    s_d.ena = wb[EV_W-1:0];
                end
                default: s_d.bresp = RESP_SLVERR;
            endcase
        end

        // core sequencing: interrupt entry, call, return, jump, step
        wake_go = wake_irq
            && (global_irq_enable_high || global_irq_enable_low);
        ret_addr = s_q.pc + PC_STEP;
        // where a push lands picks one of keep, overflow reset or plain
        // push; decoding it once keeps the three branches exclusive
        at_top = (s_q.sp == SP_MAX);
        ovr_hit = (s_q.sp == SP_MAX - SP_ONE) && s_q.ovr_en;
        // interrupt entry beats a call issued in the same cycle; both
        // push, so only one of them may be taken per clock
        if (irq_ack || wake_go) begin
            push = 1'b1;
            push_to = irq_high ? VEC_HIGH : VEC_LOW;
        end else if (call_req) begin
            push = 1'b1;
            push_to = call_target;
        end

        if (push) begin
            // latches are untouched by calls or interrupt entry, except that an overflow reset clears them
            s_d.pc = {push_to[PC_W-1:1], 1'b0};
            if (at_top) begin
                // stack already full: last entry is kept as is
                s_d.full = 1'b1;
                ev[EV_FULL] = 1'b1;
            end else if (ovr_hit) begin
                // overflow reset: store then restart, flag survives
                s_d.stk[s_q.sp] = ret_addr;
                s_d.full = 1'b1;
                s_d.sp = SP_ZERO;
                s_d.pc = PC_RESET;
                s_d.lath = '0;
                s_d.latu = '0;
                s_d.rst_pulse = 1'b1;
                ev[EV_FULL] = 1'b1;
                ev[EV_OVR] = 1'b1;
            end else begin
                sp_up = s_q.sp + SP_ONE;
                s_d.sp = sp_up;
                s_d.stk[s_q.sp] = ret_addr;
                if (sp_up == SP_MAX) begin
                    s_d.full = 1'b1;
                    ev[EV_FULL] = 1'b1;
                end
            end
        end else if (ret_req) begin
            // an empty stack has nothing to pop: flag it and restart at
            // the reset address rather than jump somewhere undefined
            if (s_q.sp == SP_ZERO) begin
                s_d.unf = 1'b1;
                s_d.pc = PC_RESET;
                ev[EV_UNF] = 1'b1;
            end else begin
                // read the entry first, then step the pointer down
                s_d.pc = s_q.stk[s_q.sp - SP_ONE];
                s_d.sp = s_q.sp - SP_ONE;
            end
        end else if (jump_req) begin
            s_d.pc = {jump_target[PC_W-1:1], 1'b0};
        end else if (step_req) begin
            s_d.pc = s_q.pc + PC_STEP;
        end
        s_d.pc[0] = 1'b0;

        // sticky status: a new event beats a clear in the same cycle
        s_d.sts = ev | (s_q.sts & ~clr);

        // reset comes last so it overrides every path above; the
        // overflow reset option returns to its enabled default
        if (!aresetn) begin
            s_d = '0;
            s_d.ovr_en = CTRL_OVR_RST;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    // no reset branch here: the synchronous reset is folded into s_d,
    // so every state bit has one clocked path and one source
    always_ff @(posedge aclk) begin
        s_q <= s_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    // a held write blocks the channel until its response is taken
    assign s_axi_awready = !s_q.aw_got && !s_q.bvalid;
    assign s_axi_wready = !s_q.w_got && !s_q.bvalid;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    // one read in flight: a new address waits until the data is taken,
    // which halves read throughput but needs no read buffer
    assign s_axi_arready = !s_q.rvalid;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;

    // counter, device reset request and level interrupt
    assign pc = s_q.pc;
    assign device_reset = s_q.rst_pulse;
    assign irq = |(s_q.sts & s_q.ena);

endmodule : pcrs_top

// ---- hdl/pcrs_pkg.sv ----
package pcrs_pkg;

    // widths of the counter, stack and bus
    localparam int PC_W = 21;
    localparam int SP_W = 5;
    localparam int DEPTH = 31;
    localparam int LATH_W = 8;
    localparam int LATU_W = 5;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 32;
    localparam int EV_W = 3;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_PC_LOW = 6'h00;
    localparam logic [ADDR_W-1:0] OFS_HIGH_LATCH = 6'h04;
    localparam logic [ADDR_W-1:0] OFS_UPPER_LATCH = 6'h08;
    localparam logic [ADDR_W-1:0] OFS_TOP_LOW = 6'h0c;
    localparam logic [ADDR_W-1:0] OFS_TOP_HIGH = 6'h10;
    localparam logic [ADDR_W-1:0] OFS_TOP_UPPER = 6'h14;
    localparam logic [ADDR_W-1:0] OFS_STACK_PTR = 6'h18;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 6'h1c;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 6'h20;
    localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR = 6'h24;
    localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 6'h28;

    // stack pointer register field positions
    localparam int SPR_UNF_BIT = 6;
    localparam int SPR_FULL_BIT = 7;
    // control register field
    localparam int CTRL_OVR_BIT = 0;
    localparam logic CTRL_OVR_RST = 1'b1;
    // interrupt event bit positions
    localparam int EV_FULL = 0;
    localparam int EV_UNF = 1;
    localparam int EV_OVR = 2;

    // counter and stack pointer constants
    localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
    localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
    localparam logic [PC_W-1:0] VEC_HIGH = 21'h000008;
    localparam logic [PC_W-1:0] VEC_LOW = 21'h000018;
    localparam logic [SP_W-1:0] SP_ONE = 5'h01;
    localparam logic [SP_W-1:0] SP_ZERO = 5'h00;
    localparam logic [SP_W-1:0] SP_MAX = 5'h1f;

    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [PC_W-1:0] pc;
        logic [LATH_W-1:0] lath;
        logic [LATU_W-1:0] latu;
        logic [SP_W-1:0] sp;
        logic full;
        logic unf;
        logic ovr_en;
        logic [DEPTH-1:0][PC_W-1:0] stk;
        logic [EV_W-1:0] sts;
        logic [EV_W-1:0] ena;
        logic aw_got;
        logic [ADDR_W-1:0] awaddr;
        logic w_got;
        logic [DATA_W-1:0] wdata;
        logic wlane0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0] rresp;
        logic rst_pulse;
    } pcrs_state_t;

endpackage : pcrs_pkg

// ---- testbench/pcrs_core_model.sv ----
`timescale 1ns/100ps
// core sequencer stand-in: each call issues one op for one cycle
module pcrs_core_model
    import pcrs_pkg::*;
(
    input wire logic aclk,
    output logic step_req,
    output logic call_req,
    output logic [PC_W-1:0] call_target,
    output logic jump_req,
    output logic [PC_W-1:0] jump_target,
    output logic ret_req,
    output logic irq_ack,
    output logic irq_high,
    output logic wake_irq
);
    logic [5:0] ops = '0;
    logic [PC_W-1:0] tgt = '0;
    // one target feeds call and jump; bit 0 also picks the vector
    assign {wake_irq, irq_ack, ret_req, jump_req, call_req, step_req} = ops;
    assign call_target = tgt;
    assign jump_target = tgt;
    assign irq_high = tgt[0];
    // k: 0 step, 1 call, 2 jump, 3 return, 4 irq ack, 5 wake
    task automatic op(input int k, input logic [PC_W-1:0] t);
        @(posedge aclk);
        tgt <= t;
        ops <= 6'h01 << k;
        @(posedge aclk);
        ops <= '0;
        #1;
    endtask : op
endmodule : pcrs_core_model

// ---- testbench/pcrs_asserts.sv ----
`timescale 1ns/100ps
// watches counter loads and the overflow reset pulse
module pcrs_asserts
    import pcrs_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic step_req,
    input wire logic call_req,
    input wire logic [PC_W-1:0] call_target,
    input wire logic jump_req,
    input wire logic [PC_W-1:0] jump_target,
    input wire logic ret_req,
    input wire logic irq_ack,
    input wire logic irq_high,
    input wire logic wake_irq,
    input wire logic global_irq_enable_high,
    input wire logic global_irq_enable_low,
    input wire logic [PC_W-1:0] pc,
    input wire logic device_reset
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic vec_op;
    logic plain;
    // a wake without any global enable does nothing at all
    assign vec_op = irq_ack || (wake_irq &&
        (global_irq_enable_high || global_irq_enable_low));
    assign plain = !vec_op && !call_req && !ret_req;
    ////////////////////////////////////////////////////////////////
    a_pc_align: assert property (pc[0] == 1'b0)
        else $error("counter bit 0 set");
    a_step_two: assert property (
        plain && !jump_req && step_req |=> pc == $past(pc) + PC_STEP)
        else $error("step did not add two");
    a_jump_load: assert property (
        plain && jump_req |=> pc == ($past(jump_target) & 21'h1ffffe))
        else $error("jump target not loaded");
    a_call_load: assert property (!vec_op && call_req |=>
        device_reset || pc == ($past(call_target) & 21'h1ffffe))
        else $error("call target not loaded");
    a_vec_load: assert property (vec_op |=> device_reset ||
        pc == ($past(irq_high) ? VEC_HIGH : VEC_LOW))
        else $error("vector not loaded");
    a_rst_once: assert property (device_reset |=> !device_reset)
        else $error("reset pulse too long");
    a_rst_pc: assert property (device_reset |-> pc == PC_RESET)
        else $error("counter not cleared by overflow");
    a_rst_cause: assert property (device_reset |->
        $past(call_req) || $past(vec_op))
        else $error("reset pulse without a push");
endmodule : pcrs_asserts

bind pcrs_top pcrs_asserts i_chk (.*);

// ---- testbench/tb.sv ----
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; \
    $display("Error at %0t: %h vs %h", $time, a, b); end end
module tb
    import pcrs_pkg::*;
;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, device_reset, irq;
    logic step_req, call_req, jump_req, ret_req, irq_ack, irq_high;
    logic wake_irq;
    logic [PC_W-1:0] call_target, jump_target, pc;
    logic global_irq_enable_high = 1'b0;
    logic global_irq_enable_low = 1'b0;
    int fail_count = 0, cmp_count = 0, cyc = 0;
    pcrs_top i_dut (.*);
    pcrs_core_model i_core (.*);
    // free-running clock and a hang guard far above the run length
    always #10 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            summarize();
        end
    end
    task automatic summarize();
        if (fail_count == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : summarize
    ////////////////////////////////////////////////////////////////
    // ready is looked at mid-cycle, where it equals its value at the edge
    task automatic wr(logic [5:0] a, logic [31:0] d, logic [1:0] e = 2'h0);
        logic ta, tw, b;
        logic [1:0] r;
        b = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        while (!b) begin
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        `CHK(r, e)
    endtask : wr
    // data is judged only when an okay answer is expected
    task automatic rchk(logic [5:0] a, logic [31:0] e, logic [1:0] er = 2'h0);
        logic t, v;
        logic [31:0] d;
        logic [1:0] r;
        v = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        while (!v) begin
            @(negedge aclk);
            t = s_axi_arvalid && s_axi_arready;
            v = s_axi_rvalid;
            {d, r} = {s_axi_rdata, s_axi_rresp};
            @(posedge aclk);
            if (t) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        `CHK(r, er)
        if (er == RESP_OKAY) `CHK(d, e)
    endtask : rchk
    ////////////////////////////////////////////////////////////////
    task automatic t_latch();
        rchk(OFS_CTRL, 32'h1);
        rchk(6'h30, 32'h0, RESP_SLVERR);
        wr(6'h30, 32'h0, RESP_SLVERR);
        wr(OFS_HIGH_LATCH, 32'h12);
        wr(OFS_UPPER_LATCH, 32'h03);
        wr(OFS_PC_LOW, 32'h57);
        `CHK(pc, 21'h031256)
        i_core.op(0, '0);
        `CHK(pc, 21'h031258)
        i_core.op(2, 21'h0abcd0);
        rchk(OFS_HIGH_LATCH, 32'h12);
        rchk(OFS_PC_LOW, 32'hd0);
        rchk(OFS_HIGH_LATCH, 32'hbc);
        rchk(OFS_UPPER_LATCH, 32'h0a);
    endtask : t_latch
    // push, replace the top by software, then return to it
    task automatic t_stack();
        wr(OFS_HIGH_LATCH, 32'h55);
        i_core.op(1, 21'h001000);
        rchk(OFS_STACK_PTR, 32'h1);
        rchk(OFS_TOP_LOW, 32'hd2);
        rchk(OFS_TOP_HIGH, 32'hbc);
        rchk(OFS_TOP_UPPER, 32'h0a);
        wr(OFS_TOP_LOW, 32'h44);
        i_core.op(3, '0);
        `CHK(pc, 21'h0abc44)
        rchk(OFS_HIGH_LATCH, 32'h55);
        wr(OFS_IRQ_ENABLE, 32'h2);
        i_core.op(3, '0);
        `CHK(pc, PC_RESET)
        rchk(OFS_STACK_PTR, 32'h40);
        `CHK(irq, 1'b1)
        wr(OFS_IRQ_ENABLE, 32'h0);
        `CHK(irq, 1'b0)
        wr(OFS_IRQ_CLEAR, 32'h2);
        rchk(OFS_IRQ_STATUS, 32'h0);
        wr(OFS_STACK_PTR, 32'h0);
    endtask : t_stack
    task automatic t_overflow();
        wr(OFS_CTRL, 32'h0);
        repeat (30) i_core.op(1, 21'h000100);
        rchk(OFS_STACK_PTR, 32'h1e);
        i_core.op(1, 21'h000100);
        rchk(OFS_STACK_PTR, 32'h9f);
        i_core.op(2, 21'h000210);
        i_core.op(1, 21'h000300);
        rchk(OFS_STACK_PTR, 32'h9f);
        rchk(OFS_TOP_LOW, 32'h02);
        wr(OFS_STACK_PTR, 32'h05);
        rchk(OFS_STACK_PTR, 32'h05);
        wr(OFS_STACK_PTR, 32'h0);
        wr(OFS_CTRL, 32'h1);
        repeat (31) i_core.op(1, 21'h000100);
        `CHK(device_reset, 1'b1)
        rchk(OFS_STACK_PTR, 32'h80);
        rchk(OFS_IRQ_STATUS, 32'h5);
        wr(OFS_IRQ_STATUS, 32'h0);
        rchk(OFS_IRQ_STATUS, 32'h5);
        wr(OFS_IRQ_CLEAR, 32'h5);
        wr(OFS_STACK_PTR, 32'h0);
    endtask : t_overflow
    // vectors by acknowledge and by wake, with and without an enable
    task automatic t_vector();
        i_core.op(4, 21'h1);
        i_core.op(4, 21'h0);
        `CHK(pc, VEC_LOW)
        @(posedge aclk);
        global_irq_enable_low <= 1'b1;
        i_core.op(5, 21'h1);
        @(posedge aclk);
        global_irq_enable_low <= 1'b0;
        `CHK(pc, VEC_HIGH)
        rchk(OFS_STACK_PTR, 32'h3);
        rchk(OFS_TOP_LOW, 32'h1a);
        i_core.op(5, 21'h0);
        `CHK(pc, VEC_HIGH)
    endtask : t_vector
    // a mid-run reset empties the stack and restores the defaults
    task automatic t_reset();
        wr(OFS_CTRL, 32'h0);
        i_core.op(1, 21'h000400);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        `CHK(pc, PC_RESET)
        rchk(OFS_STACK_PTR, 32'h0);
        rchk(OFS_CTRL, 32'h1);
        wr(OFS_STACK_PTR, 32'h1);
        rchk(OFS_TOP_LOW, 32'h0);
    endtask : t_reset
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_latch();
        t_stack();
        t_overflow();
        t_vector();
        t_reset();
        summarize();
    end
endmodule : tb
